// file: logic/lsoc_top.sv
// limit switch output compare block with apb register access
// How it works
// - up to 32 output points, any axes
// - thresholds and watch compared as signed
// - on<off: on when on<=w<off
// - on>off: on when w>=on or w<off
// - on==off: region always off
// - evaluate only while controller ready set
// - ready clears: all outputs forced off
// - capture thresholds on ready rise, each cycle
// - up to 32 regions per watch, ORed
// - assigned enable bit gates region control
// - no enable bit: always enabled
// - force bit on drives output on
// - no force bit: never forced
// - all results to one output ORed
// - point is target, watch, thresholds, enable, force
// - watch types int16, int32, float64
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`include "lsoc_map.svh"
`default_nettype none
module lsoc_top #(
    parameter int NUM_POINTS = `LSOC_POINTS,
    parameter int NUM_SRC = 8,
    parameter int OP_CYCLE_CLKS = `LSOC_OP_CYCLE_CLKS
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [NUM_SRC*64-1:0] watch_value,
    input wire logic [31:0] bit_in,
    output logic [31:0] limit_out,
    output logic controller_ready_status
);
    localparam int CNT_W = $clog2(OP_CYCLE_CLKS + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(OP_CYCLE_CLKS - 1);

    logic [31:0] cfg [NUM_POINTS];
    logic [63:0] on_sh [NUM_POINTS];
    logic [63:0] off_sh [NUM_POINTS];
    logic [63:0] on_act [NUM_POINTS];
    logic [63:0] off_act [NUM_POINTS];
    logic [63:0] watch_q [NUM_SRC];
    logic [63:0] bits_q;
    logic [31:0] sw_bits;
    logic host_ready_flag;
    logic host_ready_prev;
    lsoc_pkg::lsoc_state_e state;
    logic [CNT_W-1:0] div_cnt;
    logic op_tick;
    logic load;
    logic eval;
    logic [31:0] next_out;
    logic wr_en;
    logic rd_en;
    logic pt_hit;
    logic [4:0] pt_idx;
    logic [2:0] pt_word;
    logic glob_hit;
    logic ready_rise;
    wire [NUM_POINTS-1:0] pt_on;

    // orderable key: unsigned compare of keys equals signed compare of values
    function automatic logic [63:0] lsoc_key(input logic [63:0] v, input logic [1:0] t);
        logic [63:0] r;
        r = 64'h0;
        case (t)
            lsoc_pkg::LSOC_INT16: r = {{48{v[15]}}, v[15:0]} ^ 64'h8000_0000_0000_0000;
            lsoc_pkg::LSOC_FLT64: r = v[63] ? ~v : (v ^ 64'h8000_0000_0000_0000);
            default: r = {{32{v[31]}}, v[31:0]} ^ 64'h8000_0000_0000_0000;
        endcase
        return r;
    endfunction

    function automatic logic lsoc_region(input logic [63:0] on_k, input logic [63:0] off_k,
                                         input logic [63:0] w_k);
        logic r;
        r = 1'b0;
        if (on_k < off_k) begin
            r = (w_k >= on_k) && (w_k < off_k);
        end else if (on_k > off_k) begin
            r = (w_k >= on_k) || (w_k < off_k);
        end else begin
            r = 1'b0;
        end
        return r;
    endfunction

    function automatic logic [31:0] lsoc_strb(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // apb decode
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_en = psel && penable && !pready && !pwrite;
    assign pt_hit = (paddr[11:10] == `LSOC_PT_REGION) && (paddr[4:2] <= `LSOC_PT_OFF_HI)
        && (paddr[1:0] == 2'h0);
    assign pt_idx = paddr[9:5];
    assign pt_word = paddr[4:2];
    assign glob_hit = (paddr[11:2] <= `LSOC_BITS_OFS) && (paddr[1:0] == 2'h0);

    // one wait state: answer at the second access edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    // refused address: error flagged together with the answer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && penable && !pready && !(pt_hit || glob_hit);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0;
        end else if (rd_en) begin
            prdata <= 32'h0;
            if (pt_hit) begin
                case (pt_word)
                    `LSOC_PT_CFG: prdata <= cfg[pt_idx];
                    `LSOC_PT_ON_LO: prdata <= on_sh[pt_idx][31:0];
                    `LSOC_PT_ON_HI: prdata <= on_sh[pt_idx][63:32];
                    `LSOC_PT_OFF_LO: prdata <= off_sh[pt_idx][31:0];
                    default: prdata <= off_sh[pt_idx][63:32];
                endcase
            end else if (glob_hit) begin
                case (paddr[11:2])
                    `LSOC_CTRL_OFS: prdata <= {31'h0, host_ready_flag};
                    `LSOC_STAT_OFS: prdata <= {31'h0, controller_ready_status};
                    `LSOC_OUT_OFS: prdata <= limit_out;
                    default: prdata <= sw_bits;
                endcase
            end
        end else begin
            prdata <= 32'h0; // read data stands only in the answer cycle
        end
    end

    // host ready flag: bit 0 of the control word
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            host_ready_flag <= 1'b0;
        end else if (wr_en && glob_hit && paddr[11:2] == `LSOC_CTRL_OFS && pstrb[0]) begin
            host_ready_flag <= pwdata[`LSOC_CTRL_HOST_READY];
        end
    end

    // software bit devices, selectable as enable or force bits
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sw_bits <= `LSOC_WORD_RST;
        end else if (wr_en && glob_hit && paddr[11:2] == `LSOC_BITS_OFS) begin
            sw_bits <= lsoc_strb(sw_bits, pwdata, pstrb);
        end
    end

    // per point settings: target, watch, thresholds, enable, force
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < NUM_POINTS; p++) begin
                cfg[p] <= `LSOC_CFG_RST;
                on_sh[p] <= {`LSOC_WORD_RST, `LSOC_WORD_RST};
                off_sh[p] <= {`LSOC_WORD_RST, `LSOC_WORD_RST};
            end
        end else if (wr_en && pt_hit) begin
            case (pt_word)
                `LSOC_PT_CFG: cfg[pt_idx] <= lsoc_strb(cfg[pt_idx], pwdata, pstrb);
                `LSOC_PT_ON_LO:
                    on_sh[pt_idx][31:0] <= lsoc_strb(on_sh[pt_idx][31:0], pwdata, pstrb);
                `LSOC_PT_ON_HI:
                    on_sh[pt_idx][63:32] <= lsoc_strb(on_sh[pt_idx][63:32], pwdata, pstrb);
                `LSOC_PT_OFF_LO:
                    off_sh[pt_idx][31:0] <= lsoc_strb(off_sh[pt_idx][31:0], pwdata, pstrb);
                default:
                    off_sh[pt_idx][63:32] <= lsoc_strb(off_sh[pt_idx][63:32], pwdata, pstrb);
            endcase
        end
    end

    // operation cycle divider
    // restarts on the ready rise, so the first periodic fetch is a whole cycle plus one clock later
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_cnt <= '0;
            op_tick <= 1'b0;
        end else if (ready_rise) begin
            div_cnt <= '0;
            op_tick <= 1'b0;
        end else begin
            op_tick <= (div_cnt == CNT_LAST);
            div_cnt <= (div_cnt == CNT_LAST) ? '0 : div_cnt + 1'b1;
        end
    end

    // previous host ready level; resets to the idle level, so no false edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            host_ready_prev <= 1'b0;
        end else begin
            host_ready_prev <= host_ready_flag;
        end
    end

    assign ready_rise = host_ready_flag && !host_ready_prev;

    // ready handshake
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= lsoc_pkg::LSOC_IDLE;
        end else begin
            unique case (state)
                lsoc_pkg::LSOC_IDLE: begin
                    if (ready_rise) begin
                        state <= lsoc_pkg::LSOC_READY;
                    end
                end
                lsoc_pkg::LSOC_READY: begin
                    if (!host_ready_flag) begin
                        state <= lsoc_pkg::LSOC_IDLE;
                    end
                end
                default: state <= lsoc_pkg::LSOC_IDLE;
            endcase
        end
    end

    assign load = ready_rise
        || (op_tick && state == lsoc_pkg::LSOC_READY && host_ready_flag);

    // thresholds: captured on the ready rise, then reloaded every operation cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < NUM_POINTS; p++) begin
                on_act[p] <= 64'h0;
                off_act[p] <= 64'h0;
            end
        end else if (load) begin
            for (int p = 0; p < NUM_POINTS; p++) begin
                on_act[p] <= on_sh[p];
                off_act[p] <= off_sh[p];
            end
        end
    end

    // watch sources, fetched together with the thresholds
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int s = 0; s < NUM_SRC; s++) begin
                watch_q[s] <= 64'h0;
            end
        end else if (load) begin
            for (int s = 0; s < NUM_SRC; s++) begin
                watch_q[s] <= watch_value[s*64 +: 64];
            end
        end
    end

    // enable and force bit devices: external bits low, software bits high
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bits_q <= 64'h0;
        end else if (load) begin
            bits_q <= {sw_bits, bit_in};
        end
    end

    // evaluation strobe, one cycle after each fetch
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            eval <= 1'b0;
        end else begin
            eval <= load;
        end
    end

    // one compare per point, all in the point's own data type
    generate
        for (genvar g = 0; g < NUM_POINTS; g++) begin : g_point
            logic [1:0] typ;
            logic [63:0] w;
            logic hit;
            logic en;
            logic frc;
            assign typ = cfg[g][`LSOC_CFG_TYPE];
            assign w = watch_q[cfg[g][`LSOC_CFG_SRC] % NUM_SRC];
            assign hit = lsoc_region(lsoc_key(on_act[g], typ), lsoc_key(off_act[g], typ),
                lsoc_key(w, typ));
            assign en = !cfg[g][`LSOC_CFG_EN_ASSIGNED]
                || bits_q[cfg[g][`LSOC_CFG_EN_SEL]];
            assign frc = cfg[g][`LSOC_CFG_FRC_ASSIGNED]
                && bits_q[cfg[g][`LSOC_CFG_FRC_SEL]];
            assign pt_on[g] = cfg[g][`LSOC_CFG_USED] && ((hit && en) || frc);
        end
    endgenerate

    // merge by target: any point that is on turns on the output it is aimed at
    always_comb begin
        next_out = 32'h0;
        for (int p = 0; p < NUM_POINTS; p++) begin
            if (pt_on[p]) begin
                next_out[cfg[p][`LSOC_CFG_TGT]] = 1'b1;
            end
        end
    end

    // ready status follows the state and drops one clock after the host flag clears, at the same edge as the state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            controller_ready_status <= 1'b0;
        end else begin
            controller_ready_status <= (state == lsoc_pkg::LSOC_READY) && host_ready_flag;
        end
    end

    // outputs change only on operation cycle boundaries, except forced off when the host ready flag or state drops
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            limit_out <= 32'h0;
        end else if (!host_ready_flag || state != lsoc_pkg::LSOC_READY) begin
            limit_out <= 32'h0;
        end else if (eval) begin
            limit_out <= next_out;
        end
    end

endmodule
`default_nettype wire

// file: pkg/lsoc_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef LSOC_MAP_SVH
`define LSOC_MAP_SVH

`define LSOC_POINTS 32
`define LSOC_CTRL_OFS 10'h000
`define LSOC_STAT_OFS 10'h001
`define LSOC_OUT_OFS 10'h002
`define LSOC_BITS_OFS 10'h003
`define LSOC_PT_REGION 2'h1
`define LSOC_PT_CFG 3'h0
`define LSOC_PT_ON_LO 3'h1
`define LSOC_PT_ON_HI 3'h2
`define LSOC_PT_OFF_LO 3'h3
`define LSOC_PT_OFF_HI 3'h4
`define LSOC_CTRL_HOST_READY 0
`define LSOC_STAT_READY 0
`define LSOC_CFG_TGT 4:0
`define LSOC_CFG_SRC 7:5
`define LSOC_CFG_TYPE 9:8
`define LSOC_CFG_EN_ASSIGNED 10
`define LSOC_CFG_EN_SEL 16:11
`define LSOC_CFG_FRC_ASSIGNED 17
`define LSOC_CFG_FRC_SEL 23:18
`define LSOC_CFG_USED 24
`define LSOC_CFG_RST 32'h0000_0000
`define LSOC_WORD_RST 32'h0000_0000
`define LSOC_OP_CYCLE_US 888
`define LSOC_CLK_MHZ 25
`define LSOC_OP_CYCLE_CLKS (`LSOC_OP_CYCLE_US * `LSOC_CLK_MHZ)

`endif

// file: pkg/lsoc_pkg.sv
// types shared by the limit switch output compare block
`default_nettype none
package lsoc_pkg;
    typedef enum logic [1:0] {
        LSOC_IDLE = 2'b01,
        LSOC_READY = 2'b10
    } lsoc_state_e;
    typedef enum logic [1:0] {
        LSOC_INT16 = 2'h0,
        LSOC_INT32 = 2'h1,
        LSOC_FLT64 = 2'h2
    } lsoc_dtype_e;
    typedef logic [63:0] lsoc_word_t;
endpackage
`default_nettype wire

// file: verif/lsoc_field.sv
// field model: watch sources and bit devices seen by the block
`default_nettype none
module lsoc_field (
    input wire logic clk_sys,
    input wire logic [63:0] pos_a,
    input wire logic [63:0] pos_b,
    input wire logic [31:0] dev_bits,
    output logic [127:0] watch_value,
    output logic [31:0] bit_in
);
    // sampled bus: values land on the edge
    always_ff @(posedge clk_sys) begin
        watch_value <= {pos_b, pos_a};
        bit_in <= dev_bits;
    end
endmodule
`default_nettype wire

// file: verif/lsoc_top_properties.sv
// assertion checker for the limit switch output block
`default_nettype none
module lsoc_top_chk #(
    parameter int OP_CYCLE_CLKS = 20
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [31:0] limit_out,
    input wire logic controller_ready_status
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [31:0] lo_q;
    int gap;
    wire ctl_wr = psel && penable && pready && pwrite && paddr == 12'h000;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lo_q <= 32'h0;
        end else begin
            lo_q <= limit_out;
        end
    end
    // cycles since the last output change
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gap <= OP_CYCLE_CLKS;
        end else if (!controller_ready_status) begin
            gap <= OP_CYCLE_CLKS;
        end else if (limit_out != lo_q) begin
            gap <= 1;
        end else if (gap < OP_CYCLE_CLKS) begin
            gap <= gap + 1;
        end
    end
    chk_ready_rise: assert property (ctl_wr && pwdata[0] |-> ##3 controller_ready_status)
        else $error("ready status late");
    chk_ready_drop: assert property (ctl_wr && !pwdata[0] |-> ##2
        !controller_ready_status && limit_out == 32'h0) else $error("outputs kept after drop");
    chk_off_idle: assert property (!controller_ready_status |-> limit_out == 32'h0)
        else $error("output while not ready");
    chk_out_gap: assert property (controller_ready_status && limit_out != lo_q |->
        gap >= OP_CYCLE_CLKS) else $error("output changed inside a cycle");
    chk_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("wait state count");
    chk_pready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
    chk_err_hole: assert property (pready && paddr[11:10] == 2'h1 && paddr[4:0] >= 5'h14
        |-> pslverr) else $error("hole not refused");
    chk_rdata_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
    cov_ready: cover property ($rose(controller_ready_status));
    cov_err: cover property (pslverr);
    cov_update: cover property (controller_ready_status && limit_out != lo_q);
endmodule
bind lsoc_top lsoc_top_chk #(.OP_CYCLE_CLKS(OP_CYCLE_CLKS)) u_chk (.clk_sys(clk_sys),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .limit_out(limit_out), .controller_ready_status(controller_ready_status));
`default_nettype wire

// file: verif/tb_top.sv
// self-checking testbench for the limit switch output block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int OP = 20;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] dev_bits = 32'h0;
    logic [63:0] pos_a = 64'h0;
    logic [63:0] pos_b = 64'h0;
    logic pready, pslverr, controller_ready_status;
    logic [31:0] prdata, limit_out, bit_in;
    logic [127:0] watch_value;
    int bad_count = 0;
    int n_tests = 0;
    always #20 clk_sys = ~clk_sys;
    lsoc_field u_field (.clk_sys(clk_sys), .pos_a(pos_a), .pos_b(pos_b), .dev_bits(dev_bits),
        .watch_value(watch_value), .bit_in(bit_in));
    lsoc_top #(.NUM_SRC(2), .OP_CYCLE_CLKS(OP)) u_dut (.clk_sys(clk_sys), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .watch_value(watch_value), .bit_in(bit_in), .limit_out(limit_out),
        .controller_ready_status(controller_ready_status));
    task automatic stop_test();
        $display("compares %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (pready !== 1'b1 && i < 10);
        chk({31'h0, pready}, 32'h1);
        if (pready !== 1'b1) begin
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic pt(input int p, input logic [31:0] cfg, input logic [63:0] on,
        input logic [63:0] off);
        logic [11:0] b;
        b = 12'h400 + 12'(p * 32);
        wr(b, cfg);
        wr(b + 12'h4, on[31:0]);
        wr(b + 12'h8, on[63:32]);
        wr(b + 12'hc, off[31:0]);
        wr(b + 12'h10, off[63:32]);
    endtask
    function automatic logic [31:0] mk(input int tgt, input int src, input int typ,
        input int en, input int es, input int fr, input int fs);
        return 32'(1 << 24 | fs << 18 | fr << 17 | es << 11 | en << 10 | typ << 8 | src << 5 | tgt);
    endfunction
    task automatic t_regions();
        int tbl[5] = '{-6, -5, 0, 9, 10};
        real f;
        logic [31:0] e;
        foreach (tbl[i]) begin
            f = tbl[i] / 4.0;
            pos_a <= 64'(tbl[i]);
            pos_b <= $realtobits(f);
            repeat (2 * OP + 4) @(posedge clk_sys);
            e = 32'h0;
            e[0] = tbl[i] >= -5 && tbl[i] < 10;
            e[1] = tbl[i] >= 10 || tbl[i] < -5;
            e[3] = f >= 1.0 && f < 2.5;
            chk(limit_out, e);
        end
        wr(12'h40c, 32'h0000_000b);
        repeat (2 * OP + 4) @(posedge clk_sys);
        chk(limit_out, 32'h0000_0003);
        $display("regions test done");
    endtask
    task automatic t_bits();
        pos_a <= 64'h0;
        pos_b <= 64'h0;
        for (int k = 0; k < 4; k++) begin
            dev_bits <= {28'h0, k[0], 3'h0};
            wr(12'h00c, {31'h0, k[1]});
            repeat (2 * OP + 4) @(posedge clk_sys);
            chk(limit_out, {26'h0, k[0] | k[1], 5'h1});
        end
        $display("enable and force test done");
    endtask
    task automatic t_drop();
        logic [31:0] r;
        logic e;
        apb(1'b0, 12'h008, 32'h0, r, e);
        chk(r, 32'h21);
        apb(1'b0, 12'h004, 32'h0, r, e);
        chk(r, 32'h1);
        wr(12'h000, 32'h0);
        @(posedge clk_sys);
        chk(limit_out, 32'h0);
        chk({31'h0, controller_ready_status}, 32'h0);
        apb(1'b0, 12'h414, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        $display("ready drop test done");
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        pt(0, mk(0, 0, 1, 0, 0, 0, 0), -5, 10);
        pt(1, mk(1, 0, 0, 0, 0, 0, 0), 10, -5);
        pt(2, mk(2, 0, 1, 0, 0, 0, 0), 0, 0);
        pt(3, mk(3, 1, 2, 0, 0, 0, 0), $realtobits(1.0), $realtobits(2.5));
        pt(4, mk(5, 0, 1, 1, 3, 0, 0), -100, 100);
        pt(5, mk(5, 0, 1, 0, 0, 1, 32), 0, 0);
        wr(12'h000, 32'h1);
        t_regions();
        t_bits();
        t_drop();
        stop_test();
    end
endmodule
`default_nettype wire
